// file: rtl/dacul_pkg.sv
// Constants, field layout and mode codes of the converter update latch control
`default_nettype none

package dacul_pkg;

  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int DACUL_NCH = 2;
  localparam int DACUL_CODE_W = 12;
  localparam int DACUL_BYTE_W = 8;

  // ----------------------------------------------------------------
  // Register byte addresses on the special-function register bus
  // ----------------------------------------------------------------
  localparam logic [7:0] DACUL_A_LOW_ADDR = 8'hD2;
  localparam logic [7:0] DACUL_A_HIGH_ADDR = 8'hD3;
  localparam logic [7:0] DACUL_A_CTRL_ADDR = 8'hD4;
  localparam logic [7:0] DACUL_B_LOW_ADDR = 8'hD5;
  localparam logic [7:0] DACUL_B_HIGH_ADDR = 8'hD6;
  localparam logic [7:0] DACUL_B_CTRL_ADDR = 8'hD7;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] DACUL_CTRL_RESET = 8'h00;
  localparam logic [7:0] DACUL_HIGH_RESET = 8'h00;
  localparam logic [7:0] DACUL_LOW_RESET = 8'h00;
  localparam logic [11:0] DACUL_CODE_RESET = 12'h000;
  localparam logic [7:0] DACUL_READ_ZERO = 8'h00;

  // ----------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------
  localparam int DACUL_EN_BIT = 7;
  localparam int DACUL_MODE_HI = 4;
  localparam int DACUL_MODE_LO = 3;
  localparam int DACUL_FMT_HI = 2;
  localparam int DACUL_FMT_LO = 0;
  localparam int DACUL_FMT_WIDE_BIT = 2;
  // Bits 6 and 5 are unused: never stored, read as zero
  localparam logic [7:0] DACUL_CTRL_WMASK = 8'h9F;

  // ----------------------------------------------------------------
  // Update modes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    DACUL_MODE_ON_WRITE = 2'b00,
    DACUL_MODE_TIMER3 = 2'b01,
    DACUL_MODE_TIMER4 = 2'b10,
    DACUL_MODE_TIMER2 = 2'b11
  } dacul_mode_t;

  // ----------------------------------------------------------------
  // Justification codes (any code with bit 2 set means eight high bits)
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    DACUL_FMT_HI4 = 3'b000,
    DACUL_FMT_HI5 = 3'b001,
    DACUL_FMT_HI6 = 3'b010,
    DACUL_FMT_HI7 = 3'b011
  } dacul_fmt_t;

  // ----------------------------------------------------------------
  // Register kinds within a channel
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    DACUL_REG_LOW = 2'b00,
    DACUL_REG_HIGH = 2'b01,
    DACUL_REG_CTRL = 2'b10
  } dacul_reg_t;

endpackage : dacul_pkg

`default_nettype wire

// file: rtl/dacul_fmt_if.sv
// Interface between a channel and its data-word justifier
`default_nettype none

interface dacul_fmt_if;
  logic [7:0] high_byte;
  logic [7:0] low_byte;
  logic [2:0] fmt;
  logic [11:0] code;

  // Channel side presents bytes and format, receives the word
  modport chan (output high_byte, output low_byte, output fmt, input code);
  // Justifier side
  modport just (input high_byte, input low_byte, input fmt, output code);
endinterface : dacul_fmt_if

`default_nettype wire

// file: rtl/dacul_justify.sv
// Combinational extraction of the 12-bit word from the two data bytes
`default_nettype none

module dacul_justify
  import dacul_pkg::*;
(
  // Bytes and format in, word out
  dacul_fmt_if.just fmt_io
);

  // ----------------------------------------------------------------
  // Justification
  // ----------------------------------------------------------------
  // High bits come from the low end of the high byte, the rest from the top of the low byte
  always_comb
  begin
    fmt_io.code = {fmt_io.high_byte, fmt_io.low_byte[7:4]};
    if (!fmt_io.fmt[DACUL_FMT_WIDE_BIT])
    begin
      unique case (dacul_fmt_t'(fmt_io.fmt))
        DACUL_FMT_HI4: fmt_io.code = {fmt_io.high_byte[3:0], fmt_io.low_byte};
        DACUL_FMT_HI5: fmt_io.code = {fmt_io.high_byte[4:0], fmt_io.low_byte[7:1]};
        DACUL_FMT_HI6: fmt_io.code = {fmt_io.high_byte[5:0], fmt_io.low_byte[7:2]};
        DACUL_FMT_HI7: fmt_io.code = {fmt_io.high_byte[6:0], fmt_io.low_byte[7:3]};
      endcase
    end
  end

endmodule : dacul_justify

`default_nettype wire

// file: rtl/dacul_top.sv
// Register front end and update latches for two 12-bit voltage-output converters
//
// What this block does
// - Each channel accepts unsigned codes 0x000 to 0xFFF.
// - Two identical channels, each with three registers.
// - Disabled channel: output high impedance, low power.
// - Low byte reads return last written value.
// - High byte reads return the high latch.
// - Mode 00: high-byte write loads the latches.
// - Mode 00: low-byte write waits for high write.
// - Modes 01/10/11 latch on timer 3/4/2 overflow.
// - Three-bit format selects one of five justifications.
// - Format 000: high[3:0] then whole low byte.
// - Formats 001-1xx: 5-8 high bits, low left-justified.
// - Bit 7 enables; bits 6 and 5 read zero.
`default_nettype none

module dacul_top
  import dacul_pkg::*;
(
  // Clock and synchronous reset
  input wire logic clk_sys,
  input wire logic reset,
  // Special-function register bus
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr_en,
  input wire logic sfr_rd_en,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  // Timer overflow pulses from logic on the same clock
  input wire logic timer2_ovf,
  input wire logic timer3_ovf,
  input wire logic timer4_ovf,
  // Converter A
  output logic [11:0] dac_a_code,
  output logic dac_a_enable,
  output logic dac_a_out_hiz,
  output logic dac_a_power_down,
  // Converter B
  output logic [11:0] dac_b_code,
  output logic dac_b_enable,
  output logic dac_b_out_hiz,
  output logic dac_b_power_down
);

  // ----------------------------------------------------------------
  // Address map helpers
  // ----------------------------------------------------------------
  // Byte address of one register of one channel
  // Shared by the write strobes and the read mux so both decode identically
  function automatic logic [7:0] reg_addr(input int ch, input dacul_reg_t kind);
    logic [7:0] a;
    a = DACUL_A_LOW_ADDR;
    unique case (kind)
      DACUL_REG_LOW: a = (ch == 0) ? DACUL_A_LOW_ADDR : DACUL_B_LOW_ADDR;
      DACUL_REG_HIGH: a = (ch == 0) ? DACUL_A_HIGH_ADDR : DACUL_B_HIGH_ADDR;
      DACUL_REG_CTRL: a = (ch == 0) ? DACUL_A_CTRL_ADDR : DACUL_B_CTRL_ADDR;
      default: a = DACUL_A_LOW_ADDR;
    endcase
    return a;
  endfunction : reg_addr

  // Whether the selected timer overflow fires for a given mode
  // Unselected timers are ignored, and mode 00 ignores all of them
  function automatic logic timer_fires(input dacul_mode_t mode, input logic t2, input logic t3,
                                       input logic t4);
    logic f;
    f = 1'b0;
    unique case (mode)
      DACUL_MODE_ON_WRITE: f = 1'b0;
      DACUL_MODE_TIMER3: f = t3;
      DACUL_MODE_TIMER4: f = t4;
      DACUL_MODE_TIMER2: f = t2;
    endcase
    return f;
  endfunction : timer_fires

  // Per-channel read results and hits gathered for the read mux
  // Indexed by channel so the read mux below stays a plain priority chain
  logic [7:0] rd_val [DACUL_NCH];
  logic rd_hit [DACUL_NCH];
  logic [11:0] code_out [DACUL_NCH];
  logic en_out [DACUL_NCH];

  // ----------------------------------------------------------------
  // Channels
  // ----------------------------------------------------------------
  // Each channel owns its control, staging and latch bytes; only the bus
  // and timer overflow inputs are shared, so the two converters may run in different modes
  for (genvar ch = 0; ch < DACUL_NCH; ch++)
  begin : g_ch
    logic [7:0] ctrl_q;
    logic [7:0] stage_lo_q;
    logic [7:0] stage_hi_q;
    logic [7:0] latch_lo_q;
    logic [7:0] latch_hi_q;
    logic [11:0] code_q;
    logic wr_lo;
    logic wr_hi;
    logic wr_ctrl;
    logic upd_now;
    dacul_mode_t mode;
    dacul_fmt_if fmt_bus ();

    // Write strobes per register
    assign wr_lo = sfr_wr_en && (sfr_addr == reg_addr(ch, DACUL_REG_LOW));
    assign wr_hi = sfr_wr_en && (sfr_addr == reg_addr(ch, DACUL_REG_HIGH));
    assign wr_ctrl = sfr_wr_en && (sfr_addr == reg_addr(ch, DACUL_REG_CTRL));
    assign mode = dacul_mode_t'(ctrl_q[DACUL_MODE_HI:DACUL_MODE_LO]);

    // Update event: a high write in on-demand mode, else the selected overflow
    assign upd_now = ((mode == DACUL_MODE_ON_WRITE) && wr_hi)
                   || timer_fires(mode, timer2_ovf, timer3_ovf, timer4_ovf);

    // Bytes handed to the latches; in on-demand mode the high byte bypasses staging
    assign fmt_bus.high_byte = (mode == DACUL_MODE_ON_WRITE && wr_hi) ? sfr_wdata : stage_hi_q;
    assign fmt_bus.low_byte = stage_lo_q;
    assign fmt_bus.fmt = ctrl_q[DACUL_FMT_HI:DACUL_FMT_LO];

    // The justifier is purely combinational; its word is registered in code_q
    dacul_justify u_just (
      .fmt_io (fmt_bus)
    );

    // Control register; unused bits never stored
    always_ff @(posedge clk_sys)
    begin
      if (reset)
        ctrl_q <= DACUL_CTRL_RESET;
      else if (wr_ctrl)
        ctrl_q <= sfr_wdata & DACUL_CTRL_WMASK;
    end

    // Staging bytes hold software writes until an update event
    // A byte written in a timer mode waits here for the next selected overflow
    always_ff @(posedge clk_sys)
    begin
      if (reset)
      begin
        stage_lo_q <= DACUL_LOW_RESET;
        stage_hi_q <= DACUL_HIGH_RESET;
      end
      else
      begin
        if (wr_lo)
          stage_lo_q <= sfr_wdata;
        if (wr_hi)
          stage_hi_q <= sfr_wdata;
      end
    end

    // Input latches and the justified word; a write in the same cycle as an
    // overflow lands in staging only, the overflow copies the older bytes
    // Latches take raw bytes, so the high byte read-back does not depend on format
    always_ff @(posedge clk_sys)
    begin
      if (reset)
      begin
        latch_lo_q <= DACUL_LOW_RESET;
        latch_hi_q <= DACUL_HIGH_RESET;
        code_q <= DACUL_CODE_RESET;
      end
      else if (upd_now)
      begin
        latch_lo_q <= fmt_bus.low_byte;
        latch_hi_q <= fmt_bus.high_byte;
        code_q <= fmt_bus.code;
      end
    end

    // Read values: low from staging, high from the latch, control with zeros
    always_comb
    begin
      rd_hit[ch] = 1'b1;
      rd_val[ch] = DACUL_READ_ZERO;
      if (sfr_addr == reg_addr(ch, DACUL_REG_LOW))
        rd_val[ch] = stage_lo_q;
      else if (sfr_addr == reg_addr(ch, DACUL_REG_HIGH))
        rd_val[ch] = latch_hi_q;
      else if (sfr_addr == reg_addr(ch, DACUL_REG_CTRL))
        rd_val[ch] = ctrl_q & DACUL_CTRL_WMASK;
      else
        rd_hit[ch] = 1'b0;
    end

    assign code_out[ch] = code_q;
    assign en_out[ch] = ctrl_q[DACUL_EN_BIT];
  end

  // ----------------------------------------------------------------
  // Read data register
  // ----------------------------------------------------------------
  // Registered so the bus sees a stable byte; unmapped addresses read zero
  // Reads have no side effects, so a read may share a cycle with any write
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      sfr_rdata <= DACUL_READ_ZERO;
    else if (sfr_rd_en)
    begin
      if (rd_hit[0])
        sfr_rdata <= rd_val[0];
      else if (rd_hit[1])
        sfr_rdata <= rd_val[1];
      else
        sfr_rdata <= DACUL_READ_ZERO;
    end
  end

  // ----------------------------------------------------------------
  // Converter outputs
  // ----------------------------------------------------------------
  // The code keeps its value while disabled so re-enabling resumes the last word
  // Pin and power states follow the enable bit alone, with no added delay
  assign dac_a_code = code_out[0];
  assign dac_b_code = code_out[1];
  assign dac_a_enable = en_out[0];
  assign dac_b_enable = en_out[1];
  assign dac_a_out_hiz = !en_out[0];
  assign dac_b_out_hiz = !en_out[1];
  assign dac_a_power_down = !en_out[0];
  assign dac_b_power_down = !en_out[1];

endmodule : dacul_top

`default_nettype wire

// file: dv/dacul_top_monitor.sv
// Concurrent checks on the converter update latch control ports
`default_nettype none

module dacul_top_monitor (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Register bus
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr_en,
  input wire logic sfr_rd_en,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  // Timer overflows
  input wire logic timer2_ovf,
  input wire logic timer3_ovf,
  input wire logic timer4_ovf,
  // Converter outputs
  input wire logic [11:0] dac_a_code,
  input wire logic dac_a_enable,
  input wire logic dac_a_out_hiz,
  input wire logic dac_a_power_down,
  input wire logic dac_b_enable,
  input wire logic dac_b_out_hiz
);
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  logic [4:0] a_cfg_q;
  // No write and no overflow: nothing may move the word
  wire quiet = !sfr_wr_en && !timer2_ovf && !timer3_ovf && !timer4_ovf;
  sequence s_low_wr; sfr_wr_en && sfr_addr == 8'hD2; endsequence
  sequence s_low_rd; sfr_rd_en && sfr_addr == 8'hD2; endsequence
  sequence s_no_low_wr; !(sfr_wr_en && sfr_addr == 8'hD2); endsequence
  // Shadow of mode and format of channel A, so high writes can be judged
  always_ff @(posedge clk_sys)
    if (reset) a_cfg_q <= 5'h00;
    else if (sfr_wr_en && sfr_addr == 8'hD4) a_cfg_q <= sfr_wdata[4:0];

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  chk_a_hiz_off: assert property (dac_a_out_hiz == !dac_a_enable)
    else $error("channel a pin state wrong");
  chk_a_power_off: assert property (dac_a_power_down == !dac_a_enable)
    else $error("channel a power state wrong");
  chk_b_hiz_off: assert property (dac_b_out_hiz == !dac_b_enable)
    else $error("channel b pin state wrong");
  chk_enable_from_write: assert property
    (sfr_wr_en && sfr_addr == 8'hD4 |=> dac_a_enable == $past(sfr_wdata[7]))
    else $error("enable bit not taken");
  chk_ctrl_gap_zero: assert property (sfr_rd_en && sfr_addr == 8'hD4 |=> sfr_rdata[6:5] == 2'h0)
    else $error("unused control bits read nonzero");
  // Write, two cycles without another low write, then the read
  chk_low_read_back: assert property
    (s_low_wr ##1 s_no_low_wr [*2] ##1 s_low_rd |=> sfr_rdata == $past(sfr_wdata, 4))
    else $error("low byte read differs from write");
  chk_word_hold: assert property (quiet |=> $stable(dac_a_code))
    else $error("word moved without cause");
  chk_high_write_load: assert property
    (sfr_wr_en && sfr_addr == 8'hD3 && a_cfg_q[4:2] == 3'h1 |=> dac_a_code[11:4] == $past(sfr_wdata))
    else $error("high write did not load word");
endmodule : dacul_top_monitor

bind dacul_top dacul_top_monitor u_mon (.clk_sys(clk_sys), .reset(reset), .sfr_addr(sfr_addr),
  .sfr_wr_en(sfr_wr_en), .sfr_rd_en(sfr_rd_en), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
  .timer2_ovf(timer2_ovf), .timer3_ovf(timer3_ovf), .timer4_ovf(timer4_ovf), .dac_a_code(dac_a_code),
  .dac_a_enable(dac_a_enable), .dac_a_out_hiz(dac_a_out_hiz), .dac_a_power_down(dac_a_power_down),
  .dac_b_enable(dac_b_enable), .dac_b_out_hiz(dac_b_out_hiz));

`default_nettype wire

// file: dv/dacul_top_tb.sv
// Register-level testbench of the converter update latch control
`default_nettype none

module dacul_top_tb
  import dacul_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  localparam logic [7:0] a_lo = DACUL_A_LOW_ADDR;
  localparam logic [7:0] a_hi = DACUL_A_HIGH_ADDR;
  localparam logic [7:0] a_ct = DACUL_A_CTRL_ADDR;
  logic clk_sys, reset, sfr_wr_en, sfr_rd_en;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, h, l, hq;
  logic [2:0] tmr;
  logic [11:0] a_code, b_code, e;
  logic a_en, a_hiz, a_pd, b_en, b_hiz, b_pd;
  int err_total, compares;

  // Overflow bits: 0 timer 3, 1 timer 4, 2 timer 2, so mode m uses bit m-1
  dacul_top uut (.clk_sys(clk_sys), .reset(reset), .sfr_addr(sfr_addr), .sfr_wr_en(sfr_wr_en),
    .sfr_rd_en(sfr_rd_en), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .timer2_ovf(tmr[2]),
    .timer3_ovf(tmr[0]), .timer4_ovf(tmr[1]), .dac_a_code(a_code), .dac_a_enable(a_en),
    .dac_a_out_hiz(a_hiz), .dac_a_power_down(a_pd), .dac_b_code(b_code), .dac_b_enable(b_en),
    .dac_b_out_hiz(b_hiz), .dac_b_power_down(b_pd));

  // 20 MHz system clock
  initial
  begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
    compares++;
    if (seen !== exp)
    begin
      err_total++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  // One idle cycle between accesses keeps each strobe a clean pulse
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr_en = 1'b1;
    @(negedge clk_sys);
    sfr_wr_en = 1'b0;
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [7:0] x);
    @(negedge clk_sys);
    sfr_addr = a;
    sfr_rd_en = 1'b1;
    @(negedge clk_sys);
    sfr_rd_en = 1'b0;
    chk({4'h0, sfr_rdata}, {4'h0, x});
  endtask : rdc
  task automatic tick(input int i);
    @(negedge clk_sys);
    tmr[i] = 1'b1;
    @(negedge clk_sys);
    tmr = 3'h0;
  endtask : tick
  task automatic cc(input logic [11:0] x);
    @(negedge clk_sys);
    chk(a_code, x);
  endtask : cc
  // Expected word for a format code, worked out independently
  function automatic logic [11:0] jf(input logic [2:0] f, input logic [7:0] hb, input logic [7:0] lb);
    if (f[2]) return {hb, lb[7:4]};
    case (f[1:0])
      2'h0: return {hb[3:0], lb};
      2'h1: return {hb[4:0], lb[7:1]};
      2'h2: return {hb[5:0], lb[7:2]};
      default: return {hb[6:0], lb[7:3]};
    endcase
  endfunction : jf
  task automatic results();
    $display("compares=%0d err_total=%0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : results

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial
  begin
    {sfr_addr, sfr_wdata, sfr_wr_en, sfr_rd_en, tmr, reset} = {21'h000000, 1'b1};
    {err_total, compares, e} = '0;
    repeat (16) @(negedge clk_sys);
    reset = 1'b0;
    rdc(a_hi, 8'h00);
    chk({10'h000, a_hiz, a_pd}, 12'h003);
    wr(a_ct, 8'hFF);
    rdc(a_ct, 8'h9F);
    chk({10'h000, a_hiz, a_en}, 12'h001);
    // All eight format codes in write-triggered mode
    for (int f = 0; f < 8; f++)
    begin
      l = 8'hA5 ^ 8'(f * 17);
      h = 8'h3C + 8'(f);
      wr(a_ct, 8'h80 | 8'(f));
      wr(a_lo, l);
      cc(e);
      rdc(a_lo, l);
      wr(a_hi, h);
      e = jf(3'(f), h, l);
      cc(e);
      rdc(a_hi, h);
    end
    wr(a_ct, 8'h80);
    wr(a_lo, 8'hFF);
    wr(a_hi, 8'hFF);
    e = 12'hFFF;
    hq = 8'hFF;
    cc(e);
    // Timer modes: writes wait, other timers ignored, selected one copies
    for (int m = 1; m < 4; m++)
    begin
      l = 8'(m * 8'h30);
      h = 8'(m * 8'h25);
      wr(a_ct, 8'h84 | 8'(m << 3));
      wr(a_lo, l);
      wr(a_hi, h);
      cc(e);
      rdc(a_hi, hq);
      tick(m % 3);
      tick((m + 1) % 3);
      cc(e);
      tick(m - 1);
      e = jf(3'h4, h, l);
      hq = h;
      cc(e);
      l = ~l;
      wr(a_lo, l);
      tick(m - 1);
      e = jf(3'h4, h, l);
      cc(e);
      // Format change with no byte write: the next overflow still recopies
      wr(a_ct, 8'h80 | 8'(m << 3));
      tick(m - 1);
      e = jf(3'h0, h, l);
      cc(e);
    end
    // Second channel, then switch the first off
    wr(DACUL_B_CTRL_ADDR, 8'h80);
    wr(DACUL_B_LOW_ADDR, 8'h34);
    wr(DACUL_B_HIGH_ADDR, 8'h12);
    cc(e);
    chk(b_code, 12'h234);
    chk({9'h000, b_en, b_hiz, b_pd}, 12'h004);
    // Eight-bit use on channel B: low byte preloaded once, then only high writes
    wr(DACUL_B_CTRL_ADDR, 8'h84);
    wr(DACUL_B_LOW_ADDR, 8'h00);
    wr(DACUL_B_HIGH_ADDR, 8'h5A);
    chk(b_code, 12'h5A0);
    wr(DACUL_B_HIGH_ADDR, 8'hC3);
    chk(b_code, 12'hC30);
    wr(a_ct, 8'h00);
    chk({10'h000, a_hiz, a_pd}, 12'h003);
    rdc(8'h00, 8'h00);
    results();
  end

  // Hang guard
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    err_total++;
    results();
  end
endmodule : dacul_top_tb

`default_nettype wire
